// ---- hw/rsc_top.sv ----
// Regulator state controller: Reset, Idle and Active sequencing with fault wait.
// Assumes analog comparator flags and the serial clock arrive asynchronously.
`timescale 1ns/100ps
module rsc_top #(
  parameter int SCL_LOW_CYCLES = rsc_pkg::SCL_LOW_CYC, // Held-low detect time.
  parameter int FAULT_WAIT_CYCLES = rsc_pkg::FAULT_WAIT_CYC // Fault wait time.
) (
  input wire logic CLK, // Core clock, 125 MHz.
  input wire logic SYS_RST, // Power-on reset, sync, active high.
  input wire logic CE, // Clock enable for core state.
  input wire logic LINK_CLK, // Serial engine clock.
  input wire logic REG_REQ, // Access request pulse.
  input wire logic REG_WR, // 1 write, 0 read.
  input wire logic [7:0] REG_ADDR, // Register offset.
  input wire logic [7:0] REG_WDATA, // Write data.
  output logic REG_BUSY, // Access in flight.
  output logic REG_DONE, // Answer pulse.
  output logic [7:0] REG_RDATA, // Read data.
  output logic REG_REFUSED, // Access refused.
  input wire logic SCL_IN, // Serial clock pin level.
  input wire logic POR_TRIP, // Supply below power-on threshold.
  input wire logic VIN_BELOW_RISE, // Supply below undervoltage rising level.
  input wire logic VIN_BELOW_FALL, // Supply below undervoltage falling level.
  input wire logic DIE_OVERHEAT, // Die over-temperature comparator.
  input wire logic LIGHT_LOAD, // Load below pulse-skip threshold.
  input wire logic HK_STABLE, // Housekeeping circuits settled.
  output logic HK_PWR_EN, // Housekeeping power enable.
  output logic BUCK_EN, // Converter running.
  output logic FIXED_FREQ_OP, // 1 fixed frequency, 0 pulse skipping.
  output logic [2:0] STATE // One-hot state.
);
  import rsc_pkg::*;

  // ******************************************************
  // Register path crossing
  // ******************************************************
  rsc_xfer_if xf ();

  rsc_link_port u_link (
    .link_clk(LINK_CLK),
    .sys_rst(SYS_RST),
    .req(REG_REQ),
    .wr(REG_WR),
    .addr(REG_ADDR),
    .wdata(REG_WDATA),
    .busy(REG_BUSY),
    .done(REG_DONE),
    .rdata(REG_RDATA),
    .refused(REG_REFUSED),
    .xf(xf.link)
  );

  // ******************************************************
  // Input synchronisers
  // ******************************************************
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] async_in, meta_q, sync_q;
  logic scl_s, por_s, rise_s, fall_s, ot_s, light_s, hk_s, req_s;
  assign async_in = {xf.req_tgl, HK_STABLE, LIGHT_LOAD, DIE_OVERHEAT,
                     VIN_BELOW_FALL, VIN_BELOW_RISE, POR_TRIP, SCL_IN};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else if (CE) begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign {req_s, hk_s, light_s, ot_s, fall_s, rise_s, por_s, scl_s} = sync_q;

  logic rst_all;
  assign rst_all = SYS_RST | por_s;

  // ******************************************************
  // Access decode
  // ******************************************************
  rsc_state_t state_q, state_d;
  logic req_d_q, acc, in_reset, in_idle, in_active, wr_ok, rd_ok;
  logic ctrl_wr, sw_rst, fault_rd;
  assign acc = req_s ^ req_d_q;
  assign in_reset = (state_q == ST_RESET);
  assign in_idle = (state_q == ST_IDLE);
  assign in_active = (state_q == ST_ACTIVE);
  assign wr_ok = acc & xf.wr & ~in_reset;
  assign rd_ok = acc & ~xf.wr & ~in_reset;
  assign ctrl_wr = wr_ok & (xf.addr == OFS_CTRL);
  assign sw_rst = wr_ok & (xf.addr == OFS_RESET) & (xf.wdata == RESET_CODE);
  assign fault_rd = rd_ok & (xf.addr == OFS_FAULT);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      req_d_q <= 1'b0;
    end else if (CE) begin
      req_d_q <= req_s;
    end
  end

  // ******************************************************
  // Live faults and timers
  // ******************************************************
  logic uv_live, ot_live, fault_live, ready;
  logic [CNT_W-1:0] low_cnt_q, wait_cnt_q;
  logic held_hit, wait_q, hk_pwr_q, sw_pend_q;
  // The comparator only runs outside Reset; the falling level applies while running.
  assign uv_live = in_active ? fall_s : (in_idle & rise_s);
  assign ot_live = (in_idle | in_active) & ot_s;
  assign fault_live = uv_live | ot_live;
  assign ready = in_idle & hk_pwr_q & hk_s & ~fault_live & ~wait_q;
  assign held_hit = (low_cnt_q >= CNT_W'(SCL_LOW_CYCLES - 1));

  // Held-low timer restarts on every high sample of the serial clock.
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      low_cnt_q <= '0;
    end else if (CE) begin
      if (scl_s || in_reset) begin
        low_cnt_q <= '0;
      end else if (!held_hit) begin
        low_cnt_q <= low_cnt_q + CNT_W'(1);
      end
    end
  end

  // Fault wait starts on entry to Idle with a fault and ends early if it clears.
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      wait_q <= 1'b0;
      wait_cnt_q <= '0;
    end else if (CE) begin
      if (state_d == ST_IDLE && state_q != ST_IDLE && (ot_s || rise_s || fall_s)) begin
        wait_q <= 1'b1;
        wait_cnt_q <= '0;
      end else if (wait_q) begin
        if (!fault_live || wait_cnt_q >= CNT_W'(FAULT_WAIT_CYCLES - 1)) begin
          wait_q <= 1'b0;
        end
        wait_cnt_q <= wait_cnt_q + CNT_W'(1);
      end
    end
  end

  // ******************************************************
  // State machine
  // ******************************************************
  logic enable_q, forced_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (sw_pend_q || scl_s) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (held_hit || sw_rst) begin
          state_d = ST_RESET;
        end else if (enable_q && !fault_live) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (held_hit || sw_rst) begin
          state_d = ST_RESET;
        end else if (fault_live || !enable_q) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (rst_all) begin
      state_q <= ST_RESET;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // A software reset passes through Reset for one cycle only.
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      sw_pend_q <= 1'b0;
    end else if (CE) begin
      if (sw_rst) begin
        sw_pend_q <= 1'b1;
      end else if (in_reset) begin
        sw_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (rst_all) begin
      hk_pwr_q <= 1'b1;
    end else if (CE) begin
      if (held_hit && !in_reset) begin
        hk_pwr_q <= 1'b0;
      end else if (in_reset && state_d == ST_IDLE) begin
        hk_pwr_q <= 1'b1;
      end
    end
  end

  // ******************************************************
  // Control and sticky fault registers
  // ******************************************************
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      enable_q <= 1'b0;
      forced_q <= 1'b0;
    end else if (CE) begin
      if (in_reset) begin
        enable_q <= 1'b0;
        forced_q <= 1'b0;
      end else begin
        if (fault_live) begin
          enable_q <= 1'b0;
        end else if (ctrl_wr) begin
          enable_q <= xf.wdata[CTRL_EN_BIT] & (in_active | ready);
        end
        if (ctrl_wr) begin
          forced_q <= xf.wdata[CTRL_FF_BIT];
        end
      end
    end
  end

  logic [1:0] fault_q, fault_set;
  assign fault_set = {ot_live, uv_live};
  // A fault arriving in the cycle of the clearing read is kept.
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      fault_q <= 2'b00;
    end else if (CE) begin
      if (in_reset) begin
        fault_q <= 2'b00;
      end else begin
        fault_q <= (fault_rd ? 2'b00 : fault_q) | fault_set;
      end
    end
  end

  // ******************************************************
  // Mode output and read answers
  // ******************************************************
  logic fixed_q, buck_q;
  always_ff @(posedge CLK) begin
    if (rst_all) begin
      fixed_q <= 1'b0;
      buck_q <= 1'b0;
    end else if (CE) begin
      fixed_q <= in_active & (forced_q | ~light_s);
      buck_q <= in_active;
    end
  end

  logic [7:0] status, rd_mux;
  always_comb begin
    status = REG_RST_VAL;
    status[ST_READY_BIT] = ready;
    status[ST_UV_BIT] = uv_live;
    status[ST_OT_BIT] = ot_live;
    status[ST_FIXED_BIT] = ~in_active | forced_q | ~light_s;
    status[ST_WAIT_BIT] = wait_q;
  end

  always_comb begin
    rd_mux = REG_RST_VAL;
    case (xf.addr)
      OFS_CTRL: begin
        rd_mux[CTRL_EN_BIT] = enable_q;
        rd_mux[CTRL_FF_BIT] = forced_q;
      end
      OFS_STATUS: begin
        rd_mux = status;
      end
      OFS_FAULT: begin
        rd_mux[FLT_UV_BIT] = fault_q[0];
        rd_mux[FLT_OT_BIT] = fault_q[1];
      end
      default: begin
        rd_mux = REG_RST_VAL;
      end
    endcase
  end

  // Answer data settles in the same edge as the toggle, so the port sees it stable.
  // A supply trip leaves the handshake running, so the link never sees a false or lost answer.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      xf.ack_tgl <= 1'b0;
      xf.rdata <= REG_RST_VAL;
      xf.refused <= 1'b0;
    end else if (CE && acc) begin
      xf.ack_tgl <= ~xf.ack_tgl;
      xf.rdata <= (rd_ok && !por_s) ? rd_mux : REG_RST_VAL;
      xf.refused <= in_reset | por_s;
    end
  end

  assign HK_PWR_EN = hk_pwr_q;
  assign BUCK_EN = buck_q;
  assign FIXED_FREQ_OP = fixed_q;
  assign STATE = state_q;

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (rst_all || !CE);

  property p_stay_reset;
    in_reset && !sw_pend_q && !scl_s && $stable(CE) |=> in_reset;
  endproperty
  a_stay_reset: assert property (p_stay_reset) else $error("left Reset with clock low");

  property p_reset_exit;
    in_reset && scl_s ##1 CE |-> in_idle;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("no Idle after clock high");

  property p_refuse;
    acc && in_reset ##1 CE |-> xf.refused && xf.rdata == 8'h00 && fault_q == 2'b00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("access taken in Reset");

  property p_held_low;
    held_hit && !in_reset ##1 CE |-> in_reset && !hk_pwr_q;
  endproperty
  a_held_low: assert property (p_held_low) else $error("held-low reset missed");

  property p_sw_reset;
    sw_rst ##1 CE [*2] |-> $past(in_reset) && in_idle;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset path wrong");

  property p_enable_refused;
    ctrl_wr && xf.wdata[CTRL_EN_BIT] && in_idle && fault_live ##1 CE |-> !enable_q;
  endproperty
  a_enable_refused: assert property (p_enable_refused) else $error("enable kept");

  property p_active_exit;
    in_active && fault_live && !held_hit && !sw_rst ##1 CE |-> in_idle && !enable_q ##1 !buck_q;
  endproperty
  a_active_exit: assert property (p_active_exit) else $error("Active kept on fault");

  property p_sticky;
    fault_live ##1 CE |-> fault_q != 2'b00;
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky fault not set");

  property p_ready_fault;
    status[ST_READY_BIT] |-> in_idle && !ot_s && !wait_q;
  endproperty
  a_ready_fault: assert property (p_ready_fault) else $error("ready with fault");
endmodule

// ---- hw/rsc_pkg.sv ----
// Constants, register map and state codes of the regulator state controller.
// Assumes a 125 MHz core clock; rsc_top and the testbench import this package.
package rsc_pkg;
  // ******************************************************
  // Clock and timing
  // ******************************************************
  localparam int CLK_MHZ = 125;
  localparam int SCL_LOW_TIME_MS = 100;
  localparam int FAULT_WAIT_TIME_MS = 20;
  localparam int SCL_LOW_CYC = SCL_LOW_TIME_MS * 1000 * CLK_MHZ;
  localparam int FAULT_WAIT_CYC = FAULT_WAIT_TIME_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;
  // ******************************************************
  // Register map
  // ******************************************************
  localparam logic [7:0] OFS_CTRL = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_RESET = 8'h03;
  localparam logic [7:0] OFS_FAULT = 8'h04;
  // Reset code value is arbitrary.
  localparam logic [7:0] RESET_CODE = 8'hA5;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FF_BIT = 1;
  localparam int ST_READY_BIT = 0;
  localparam int ST_UV_BIT = 1;
  localparam int ST_OT_BIT = 2;
  localparam int ST_FIXED_BIT = 3;
  localparam int ST_WAIT_BIT = 4;
  localparam int FLT_UV_BIT = 0;
  localparam int FLT_OT_BIT = 1;
  localparam logic [7:0] REG_RST_VAL = 8'h00;
  // ******************************************************
  // States
  // ******************************************************
  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_IDLE = 3'h2,
    ST_ACTIVE = 3'h4
  } rsc_state_t;
endpackage

// ---- hw/rsc_xfer_if.sv ----
// Register transfer bundle between the link-clock port and the core.
// Each signal is driven in one clock domain only; data is held while a toggle is open.
`timescale 1ns/100ps
interface rsc_xfer_if;
  logic req_tgl;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack_tgl;
  logic [7:0] rdata;
  logic refused;
  modport link (output req_tgl, wr, addr, wdata, input ack_tgl, rdata, refused);
  modport core (input req_tgl, wr, addr, wdata, output ack_tgl, rdata, refused);
endinterface

// ---- hw/rsc_link_port.sv ----
// Link-clock side of the register path: takes one access, hands it over by toggle.
// Assumes the serial engine keeps req low while busy is high.
`timescale 1ns/100ps
module rsc_link_port (
  input wire logic link_clk, // Link clock.
  input wire logic sys_rst, // Core reset, resynchronised here.
  input wire logic req, // Access request pulse.
  input wire logic wr, // 1 write, 0 read.
  input wire logic [7:0] addr, // Register offset.
  input wire logic [7:0] wdata, // Write data.
  output logic busy, // Access in flight.
  output logic done, // Answer pulse.
  output logic [7:0] rdata, // Read data.
  output logic refused, // Access refused.
  rsc_xfer_if.link xf // Toward the core.
);
  logic rst_m_q, rst_q, ack_m_q, ack_s_q, ack_d_q;
  always_ff @(posedge link_clk) begin
    rst_m_q <= sys_rst;
    rst_q <= rst_m_q;
  end
  always_ff @(posedge link_clk) begin
    if (rst_q) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      ack_d_q <= 1'b0;
    end else begin
      ack_m_q <= xf.ack_tgl;
      ack_s_q <= ack_m_q;
      ack_d_q <= ack_s_q;
    end
  end
  always_ff @(posedge link_clk) begin
    if (rst_q) begin
      xf.req_tgl <= 1'b0;
      xf.wr <= 1'b0;
      xf.addr <= 8'h00;
      xf.wdata <= 8'h00;
      busy <= 1'b0;
    end else if (req && !busy) begin
      xf.req_tgl <= ~xf.req_tgl;
      xf.wr <= wr;
      xf.addr <= addr;
      xf.wdata <= wdata;
      busy <= 1'b1;
    end else if (ack_s_q ^ ack_d_q) begin
      busy <= 1'b0;
    end
  end
  always_ff @(posedge link_clk) begin
    if (rst_q) begin
      done <= 1'b0;
      rdata <= 8'h00;
      refused <= 1'b0;
    end else begin
      done <= ack_s_q ^ ack_d_q;
      if (ack_s_q ^ ack_d_q) begin
        rdata <= xf.rdata;
        refused <= xf.refused;
      end
    end
  end
endmodule

// ---- dv/rsc_host_model.sv ----
// Host-side model: drives the serial clock level and one register access at a time.
// Assumes the link-clock access port of the regulator state controller opposite.
`timescale 1ns/100ps
module rsc_host_model (
  input wire logic link_clk, // Link clock.
  output logic scl, // Serial clock level.
  output logic req, // Request pulse.
  output logic wr, // Write select.
  output logic [7:0] addr, // Register offset.
  output logic [7:0] wdata, // Write data.
  input wire logic done, // Answer pulse.
  input wire logic [7:0] rdata, // Read data.
  input wire logic refused // Refusal flag.
);
  initial begin
    scl = 1'b0;
    req = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  task automatic set_scl(input logic v);
    @(posedge link_clk) scl <= v;
  endtask

  // The device decodes nothing reliably until its front end has settled.
  task automatic release_scl;
    set_scl(1'b1);
    repeat (1700) @(posedge link_clk);
  endtask

  // Qualifiers are inverted once taken, so a stale value can never look valid.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] rd, output logic rf, output logic ok);
    int n;
    @(posedge link_clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge link_clk);
    req <= 1'b0;
    wr <= ~w;
    addr <= ~a;
    wdata <= ~d;
    n = 0;
    while (n < 60 && done !== 1'b1) begin
      @(posedge link_clk);
      n++;
    end
    rd = rdata;
    rf = refused;
    ok = (done === 1'b1);
  endtask
endmodule

// ---- dv/rsc_top_test.sv ----
// Self-checking testbench of the regulator state controller.
// Assumes rsc_pkg, the design files and the host model are compiled before it.
`timescale 1ns/100ps
module rsc_top_test;
  import rsc_pkg::*;
  localparam int LOW_CYC = 200;
  localparam int WAIT_CYC = 100;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic por_trip = 1'b0;
  logic vin_below_rise = 1'b0;
  logic vin_below_fall = 1'b0;
  logic die_overheat = 1'b0;
  logic light_load = 1'b0;
  logic hk_stable = 1'b1;
  logic scl, req, wr, done, refused, busy, hk_pwr_en, buck_en, fixed_freq_op;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] state;
  int error_cnt = 0;
  int check_count = 0;

  always #4 clk = ~clk;
  // The 12 ns link clock never shares a rising edge with the 8 ns core clock.
  always #6 link_clk = ~link_clk;

  rsc_top #(.SCL_LOW_CYCLES(LOW_CYC), .FAULT_WAIT_CYCLES(WAIT_CYC)) rsc_top_i (
    .CLK(clk), .SYS_RST(sys_rst), .CE(1'b1), .LINK_CLK(link_clk), .REG_REQ(req),
    .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_BUSY(busy), .REG_DONE(done),
    .REG_RDATA(rdata), .REG_REFUSED(refused), .SCL_IN(scl), .POR_TRIP(por_trip),
    .VIN_BELOW_RISE(vin_below_rise), .VIN_BELOW_FALL(vin_below_fall),
    .DIE_OVERHEAT(die_overheat), .LIGHT_LOAD(light_load), .HK_STABLE(hk_stable),
    .HK_PWR_EN(hk_pwr_en), .BUCK_EN(buck_en), .FIXED_FREQ_OP(fixed_freq_op), .STATE(state)
  );

  rsc_host_model rsc_host_model_i (
    .link_clk(link_clk), .scl(scl), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
    .done(done), .rdata(rdata), .refused(refused)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic clk_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_st(input logic [2:0] exp, input int n);
    int i;
    i = 0;
    while (i < n && state !== exp) begin
      @(posedge clk);
      i++;
    end
    chk("state", {5'h00, exp}, {5'h00, state});
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] m, input logic [7:0] exp, input logic rf_exp);
    logic [7:0] rd;
    logic rf;
    logic ok;
    rsc_host_model_i.access(w, a, d, rd, rf, ok);
    chk("answer", 8'h01, {7'h00, ok});
    chk("busy", 8'h00, {7'h00, busy});
    chk("refused", {7'h00, rf_exp}, {7'h00, rf});
    chk("rdata", exp & m, rd & m);
  endtask

  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 8'h00, 8'h00, 1'b0);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00, m, exp, 1'b0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    clk_n(5);
    sys_rst <= 1'b0;
    clk_n(30);
    chk("state", 8'h01, {5'h00, state});
    xfer(1'b1, OFS_CTRL, 8'h01, 8'h00, 8'h00, 1'b1);
    xfer(1'b0, OFS_CTRL, 8'h00, 8'hFF, 8'h00, 1'b1);
    rsc_host_model_i.set_scl(1'b1);
    wait_st(ST_IDLE, 20);
    rdm(OFS_CTRL, 8'hFF, 8'h00);
    rdm(OFS_STATUS, 8'hFF, 8'h09);
    wrt(OFS_STATUS, 8'h00);
    rdm(OFS_STATUS, 8'hFF, 8'h09);
    rdm(8'h7F, 8'hFF, 8'h00);
    wrt(OFS_CTRL, 8'h02);
    rdm(OFS_CTRL, 8'hFF, 8'h02);
    wrt(OFS_CTRL, 8'h01);
    wait_st(ST_ACTIVE, 40);
    clk_n(2);
    chk("buck", 8'h01, {7'h00, buck_en});
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) light_load <= k[0];
      wrt(OFS_CTRL, {6'h00, k[1], 1'b1});
      clk_n(6);
      chk("fixed", {7'h00, k[1] | ~k[0]}, {7'h00, fixed_freq_op});
    end
    @(posedge clk) die_overheat <= 1'b1;
    wait_st(ST_IDLE, 20);
    rdm(OFS_CTRL, 8'h01, 8'h00);
    rdm(OFS_STATUS, 8'h15, 8'h14);
    wrt(OFS_CTRL, 8'h01);
    rdm(OFS_CTRL, 8'h01, 8'h00);
    chk("state", 8'h02, {5'h00, state});
    clk_n(WAIT_CYC + 10);
    rdm(OFS_STATUS, 8'h11, 8'h00);
    @(posedge clk) die_overheat <= 1'b0;
    clk_n(6);
    rdm(OFS_STATUS, 8'h05, 8'h01);
    rdm(OFS_FAULT, 8'h02, 8'h02);
    rdm(OFS_FAULT, 8'h02, 8'h00);
    wrt(OFS_CTRL, 8'h01);
    wait_st(ST_ACTIVE, 40);
    @(posedge clk) vin_below_fall <= 1'b1;
    wait_st(ST_IDLE, 20);
    rdm(OFS_CTRL, 8'h01, 8'h00);
    rdm(OFS_FAULT, 8'h01, 8'h01);
    @(posedge clk) vin_below_fall <= 1'b0;
    clk_n(6);
    rdm(OFS_FAULT, 8'h03, 8'h00);
    wrt(OFS_CTRL, 8'h01);
    wait_st(ST_ACTIVE, 40);
    wrt(OFS_RESET, 8'h5A);
    clk_n(10);
    chk("state", 8'h04, {5'h00, state});
    wrt(OFS_RESET, RESET_CODE);
    wait_st(ST_IDLE, 20);
    rdm(OFS_CTRL, 8'hFF, 8'h00);
    rsc_host_model_i.set_scl(1'b0);
    clk_n(150);
    rsc_host_model_i.set_scl(1'b1);
    clk_n(4);
    rsc_host_model_i.set_scl(1'b0);
    clk_n(150);
    chk("state", 8'h02, {5'h00, state});
    wait_st(ST_RESET, LOW_CYC);
    chk("hk_pwr", 8'h00, {7'h00, hk_pwr_en});
    @(posedge clk) hk_stable <= 1'b0;
    vin_below_rise <= 1'b1;
    clk_n(30);
    chk("state", 8'h01, {5'h00, state});
    xfer(1'b0, OFS_CTRL, 8'h00, 8'hFF, 8'h00, 1'b1);
    rsc_host_model_i.release_scl();
    wait_st(ST_IDLE, 20);
    chk("hk_pwr", 8'h01, {7'h00, hk_pwr_en});
    rdm(OFS_STATUS, 8'h03, 8'h02);
    @(posedge clk) vin_below_rise <= 1'b0;
    clk_n(6);
    rdm(OFS_STATUS, 8'h01, 8'h00);
    wrt(OFS_CTRL, 8'h01);
    rdm(OFS_CTRL, 8'h01, 8'h00);
    @(posedge clk) hk_stable <= 1'b1;
    clk_n(6);
    rdm(OFS_STATUS, 8'h01, 8'h01);
    wrt(OFS_CTRL, 8'h01);
    wait_st(ST_ACTIVE, 40);
    @(posedge clk) por_trip <= 1'b1;
    clk_n(8);
    chk("state", 8'h01, {5'h00, state});
    chk("buck", 8'h00, {7'h00, buck_en});
    @(posedge clk) por_trip <= 1'b0;
    wait_st(ST_IDLE, 20);
    rdm(OFS_CTRL, 8'hFF, 8'h00);
    tally_and_finish();
  end

  // A hung handshake must still end the run with a verdict.
  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
